// ===== ssq_sequencer.sv
// Sample sequencer: four triggered step lists driving a converter core,
// per-sequence output FIFOs, sticky overflow/underflow flags and interrupt.
// Assumes the converter answers each start pulse with one conv_done pulse.
//
// Notes on behaviour
// - Trigger on enabled sequence with unread FIFO samples sets its overflow flag.
// - Overflow flag stays until software clears it; otherwise harmless.
// - Reading an empty sequence FIFO sets its underflow flag.
// - Underflow flag stays until software clears it; otherwise harmless.
// - Step mode bit set makes that conversion differential unless the temperature bit is set, else single-ended.
// - Step channel field selects one of eight inputs, zero to seven.
// - Step temperature bit converts the internal sensor instead of the channel.
// - Step end marker stops the sequence after that step.
// - Step interrupt bit raises the sequence interrupt status on completion.
// - Steps run in ascending order from zero, results pushed in order.
// - Step slots are eight, four, four and one for sequences zero to three.
// - Differential channel field is pair number n, inputs 2n and 2n+1.
// - Step settings are captured when the run starts and govern that run.
// - Each sequence has its own FIFO; each read of a non-empty FIFO pops one word.
// - Four sequences with capacities eight, four, four and one samples.
// - Two-bit priority, zero highest, arbitrates simultaneous pending triggers.
// - Disabled sequence ignores its trigger and captures nothing.
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module ssq_sequencer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ssq_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [ssq_pkg::NUM_SEQ-1:0] trig_in,
    output logic conv_start,
    output logic [2:0] conv_input_p,
    output logic [2:0] conv_input_n,
    output logic conv_diff,
    output logic conv_temp,
    input wire logic conv_done,
    input wire logic [ssq_pkg::DATA_W-1:0] conv_data,
    output logic irq
);

    // ************************************************************
    // State
    // ************************************************************
    ssq_mem_if mem_bus ();

    logic [3:0] seq_en;
    logic [7:0] seq_prio;
    logic [3:0] pending;
    logic [3:0] ovf;
    logic [3:0] unf;
    logic [ssq_pkg::IRQ_W-1:0] irq_stat;
    logic [ssq_pkg::IRQ_W-1:0] irq_mask;
    logic [ssq_pkg::CFG_W-1:0] step_cfg [4][8];
    logic [ssq_pkg::CFG_W-1:0] run_cfg [8];
    logic [3:0] fill [4];
    logic [2:0] wptr [4];
    logic [2:0] rptr [4];
    ssq_pkg::ssq_state_e state;
    logic [1:0] cur_seq;
    logic [2:0] step_index;
    logic bus_phase;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic is_step(input logic [7:0] a);
        logic [7:0] off;
        off = a - ssq_pkg::REG_STEP_BASE;
        return (a >= ssq_pkg::REG_STEP_BASE) && (off < ssq_pkg::REG_STEP_SPAN)
            && (a[1:0] == 2'h0) && ({1'b0, off[4:2]} < ssq_pkg::seq_cap(off[6:5]));
    endfunction : is_step

    function automatic logic is_fifo(input logic [7:0] a);
        return (a >= ssq_pkg::REG_FIFO_BASE)
            && (a < ssq_pkg::REG_FIFO_BASE + ssq_pkg::REG_FIFO_SPAN) && (a[1:0] == 2'h0);
    endfunction : is_fifo

    function automatic logic [2:0] next_ptr(input logic [2:0] p, input logic [1:0] s);
        logic [3:0] cap;
        cap = ssq_pkg::seq_cap(s);
        return ({1'b0, p} == cap - 4'h1) ? 3'h0 : 3'(p + 3'h1);
    endfunction : next_ptr

    // Lowest priority value wins; ties are a software fault and go to lower index
    function automatic logic [2:0] pick(input logic [3:0] p, input logic [7:0] pr);
        logic [2:0] res;
        res = 3'h0;
        for (int lvl = 0; lvl < 4; lvl++) begin
            for (int s = 0; s < 4; s++) begin
                if (!res[2] && p[s] && pr[2*s +: 2] == 2'(lvl)) begin
                    res = {1'b1, 2'(s)};
                end
            end
        end
        return res;
    endfunction : pick

    logic bus_take;
    logic wr_take;
    logic rd_take;
    logic [7:0] step_off;
    logic [7:0] fifo_off;
    logic [1:0] fifo_seq;
    logic [3:0] trig_evt;
    logic [3:0] trig_acc;
    logic [3:0] nonempty;
    logic [3:0] ovf_evt;
    logic [3:0] unf_evt;
    logic [3:0] ovf_clr;
    logic [3:0] unf_clr;
    logic [3:0] pop;
    logic [3:0] push;
    logic [3:0] done_evt;
    logic [3:0] start_clr;
    logic [2:0] pick_res;
    logic [ssq_pkg::CFG_W-1:0] cur_cfg;
    logic run_end;
    logic [31:0] next_readdata;

    assign bus_take = (read | write) & ~waitrequest;
    assign wr_take = bus_take & write;
    assign rd_take = bus_take & read;
    assign step_off = address - ssq_pkg::REG_STEP_BASE;
    assign fifo_off = address - ssq_pkg::REG_FIFO_BASE;
    assign fifo_seq = fifo_off[3:2];
    assign cur_cfg = run_cfg[step_index];
    assign pick_res = pick(pending, seq_prio);
    assign run_end = cur_cfg[ssq_pkg::CFG_LAST]
        || ({1'b0, step_index} == ssq_pkg::seq_cap(cur_seq) - 4'h1);

    always_comb begin
        trig_evt = trig_in;
        if (wr_take && address == ssq_pkg::REG_TRIGGER) begin
            trig_evt = trig_in | writedata[3:0];
        end
        trig_acc = trig_evt & seq_en;
        ovf_clr = (wr_take && address == ssq_pkg::REG_OVF) ? writedata[3:0] : 4'h0;
        unf_clr = (wr_take && address == ssq_pkg::REG_UNF) ? writedata[3:0] : 4'h0;
        start_clr = 4'h0;
        if (state == ssq_pkg::ST_IDLE && pick_res[2]) begin
            start_clr = 4'(4'h1 << pick_res[1:0]);
        end
        for (int s = 0; s < 4; s++) begin
            nonempty[s] = fill[s] != 4'h0;
            ovf_evt[s] = trig_acc[s] && nonempty[s];
            pop[s] = rd_take && is_fifo(address) && fifo_seq == 2'(s) && nonempty[s];
            unf_evt[s] = rd_take && is_fifo(address) && fifo_seq == 2'(s) && !nonempty[s];
            push[s] = state == ssq_pkg::ST_WAIT && conv_done && cur_seq == 2'(s)
                && fill[s] < ssq_pkg::seq_cap(2'(s));
            done_evt[s] = state == ssq_pkg::ST_WAIT && conv_done && cur_seq == 2'(s)
                && cur_cfg[ssq_pkg::CFG_IRQ];
        end
    end

    // ************************************************************
    // Avalon-MM slave: answer two cycles after a request is raised
    // ************************************************************
    always_comb begin
        next_readdata = 32'h0;
        case (address)
            ssq_pkg::REG_ENABLE: next_readdata[3:0] = seq_en;
            ssq_pkg::REG_PRIO: next_readdata[7:0] = seq_prio;
            ssq_pkg::REG_OVF: next_readdata[3:0] = ovf;
            ssq_pkg::REG_UNF: next_readdata[3:0] = unf;
            ssq_pkg::REG_IRQ_STAT: next_readdata[ssq_pkg::IRQ_W-1:0] = irq_stat;
            ssq_pkg::REG_IRQ_MASK: next_readdata[ssq_pkg::IRQ_W-1:0] = irq_mask;
            ssq_pkg::REG_STATUS: begin
                next_readdata[15:0] = {fill[3], fill[2], fill[1], fill[0]};
                next_readdata[ssq_pkg::STAT_SEQ_LSB +: 2] = cur_seq;
                next_readdata[ssq_pkg::STAT_BUSY] = state != ssq_pkg::ST_IDLE;
            end
            default: begin
                if (is_fifo(address) && nonempty[fifo_seq]) begin
                    next_readdata[ssq_pkg::DATA_W-1:0] = mem_bus.rdata;
                end else if (is_step(address)) begin
                    next_readdata[ssq_pkg::CFG_W-1:0] = step_cfg[step_off[6:5]][step_off[4:2]];
                end
            end
        endcase
    end

    // The extra phase gives the sample store one edge to present its word
    always_ff @(posedge clk) begin
        if (!rstn) begin
            waitrequest <= 1'b1;
            bus_phase <= 1'b0;
            readdata <= 32'h0;
        end else if (bus_take) begin
            waitrequest <= 1'b1;
            bus_phase <= 1'b0;
        end else if (read || write) begin
            if (bus_phase) begin
                waitrequest <= 1'b0;
                readdata <= next_readdata;
            end
            bus_phase <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            seq_en <= 4'h0;
            seq_prio <= ssq_pkg::PRIO_RST;
            irq_mask <= '0;
        end else if (wr_take) begin
            if (address == ssq_pkg::REG_ENABLE) begin
                seq_en <= writedata[3:0];
            end
            if (address == ssq_pkg::REG_PRIO) begin
                seq_prio <= writedata[7:0];
            end
            if (address == ssq_pkg::REG_IRQ_MASK) begin
                irq_mask <= writedata[ssq_pkg::IRQ_W-1:0];
            end
        end
    end

    // Step words have no reset; software programs them before enabling
    always_ff @(posedge clk) begin
        if (wr_take && is_step(address)) begin
            step_cfg[step_off[6:5]][step_off[4:2]] <= writedata[ssq_pkg::CFG_W-1:0];
        end
    end

    // ************************************************************
    // Sticky flags and interrupt; a new event beats a same-cycle clear
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ovf <= 4'h0;
            unf <= 4'h0;
        end else begin
            ovf <= (ovf & ~ovf_clr) | ovf_evt;
            unf <= (unf & ~unf_clr) | unf_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_stat <= '0;
            irq <= 1'b0;
        end else begin
            if (rd_take && address == ssq_pkg::REG_IRQ_STAT) begin
                irq_stat <= {unf_evt, ovf_evt, done_evt};
            end else begin
                irq_stat <= irq_stat | {unf_evt, ovf_evt, done_evt};
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pending <= 4'h0;
        end else begin
            pending <= (pending & ~start_clr) | trig_acc;
        end
    end

    // ************************************************************
    // Step engine
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ssq_pkg::ST_IDLE;
            cur_seq <= 2'h0;
            step_index <= 3'h0;
        end else begin
            case (state)
                ssq_pkg::ST_IDLE: begin
                    if (pick_res[2]) begin
                        cur_seq <= pick_res[1:0];
                        step_index <= 3'h0;
                        state <= ssq_pkg::ST_START;
                    end
                end
                ssq_pkg::ST_START: state <= ssq_pkg::ST_WAIT;
                ssq_pkg::ST_WAIT: begin
                    if (conv_done) begin
                        if (run_end) begin
                            state <= ssq_pkg::ST_IDLE;
                        end else begin
                            step_index <= 3'(step_index + 3'h1);
                            state <= ssq_pkg::ST_START;
                        end
                    end
                end
                default: state <= ssq_pkg::ST_IDLE;
            endcase
        end
    end

    // Snapshot keeps a run consistent while software rewrites step words
    always_ff @(posedge clk) begin
        if (state == ssq_pkg::ST_IDLE && pick_res[2]) begin
            for (int i = 0; i < ssq_pkg::MAX_STEPS; i++) begin
                run_cfg[i] <= step_cfg[pick_res[1:0]][i];
            end
        end
    end

    // Differential with the sensor is undefined; the sensor is given precedence
    always_ff @(posedge clk) begin
        if (!rstn) begin
            conv_start <= 1'b0;
            conv_input_p <= 3'h0;
            conv_input_n <= 3'h0;
            conv_diff <= 1'b0;
            conv_temp <= 1'b0;
        end else begin
            conv_start <= state == ssq_pkg::ST_START;
            if (state == ssq_pkg::ST_START) begin
                conv_temp <= cur_cfg[ssq_pkg::CFG_TEMP];
                conv_diff <= cur_cfg[ssq_pkg::CFG_DIFF] & ~cur_cfg[ssq_pkg::CFG_TEMP];
                if (cur_cfg[ssq_pkg::CFG_DIFF]) begin
                    conv_input_p <= {cur_cfg[ssq_pkg::CFG_SEL_LO +: 2], 1'b0};
                    conv_input_n <= {cur_cfg[ssq_pkg::CFG_SEL_LO +: 2], 1'b1};
                end else begin
                    conv_input_p <= cur_cfg[ssq_pkg::CFG_SEL_LO +: 3];
                    conv_input_n <= cur_cfg[ssq_pkg::CFG_SEL_LO +: 3];
                end
            end
        end
    end

    // ************************************************************
    // Output FIFOs; a sample finding its FIFO full is dropped
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int s = 0; s < 4; s++) begin
                fill[s] <= 4'h0;
                wptr[s] <= 3'h0;
                rptr[s] <= 3'h0;
            end
        end else begin
            for (int s = 0; s < 4; s++) begin
                fill[s] <= 4'(fill[s] + {3'h0, push[s]} - {3'h0, pop[s]});
                if (push[s]) begin
                    wptr[s] <= next_ptr(wptr[s], 2'(s));
                end
                if (pop[s]) begin
                    rptr[s] <= next_ptr(rptr[s], 2'(s));
                end
            end
        end
    end

    assign mem_bus.wr_en = |push;
    assign mem_bus.waddr = {cur_seq, wptr[cur_seq]};
    assign mem_bus.wdata = conv_data;
    assign mem_bus.raddr = {fifo_seq, rptr[fifo_seq]};

    ssq_sample_mem u_mem (
        .clk(clk),
        .port(mem_bus.mem)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_run_begin;
        state == ssq_pkg::ST_IDLE && pick_res[2];
    endsequence

    sequence s_step_done;
        state == ssq_pkg::ST_WAIT && conv_done;
    endsequence

    a_ovf_on_trig: assert property (
        (ovf_evt != 4'h0) |=> ((ovf & $past(ovf_evt)) == $past(ovf_evt)))
        else $error("overflow flag not set by trigger on unread FIFO");
    a_ovf_held: assert property (
        (ovf & ~ovf_clr) != 4'h0 |=> ((ovf & $past(ovf & ~ovf_clr)) == $past(ovf & ~ovf_clr)))
        else $error("overflow flag dropped without a clear");
    a_unf_on_empty: assert property (
        (unf_evt != 4'h0) |=> ((unf & $past(unf_evt)) == $past(unf_evt)))
        else $error("underflow flag not set by read of empty FIFO");
    a_unf_held: assert property (
        (unf & ~unf_clr) != 4'h0 |=> ((unf & $past(unf & ~unf_clr)) == $past(unf & ~unf_clr)))
        else $error("underflow flag dropped without a clear");
    a_diff_pair: assert property (
        conv_start && conv_diff |-> !conv_input_p[0] && conv_input_n == 3'(conv_input_p + 3'h1))
        else $error("differential inputs not an adjacent pair");
    a_chan_single: assert property (
        state == ssq_pkg::ST_START && !cur_cfg[ssq_pkg::CFG_DIFF]
        |=> conv_start && !conv_diff && conv_input_p == $past(cur_cfg[2:0]))
        else $error("single-ended channel not driven from step word");
    a_temp_sel: assert property (
        state == ssq_pkg::ST_START && cur_cfg[ssq_pkg::CFG_TEMP] |=> conv_temp && !conv_diff)
        else $error("temperature sensor step not flagged to converter");
    a_end_stop: assert property (
        s_step_done ##0 cur_cfg[ssq_pkg::CFG_LAST] |=> state == ssq_pkg::ST_IDLE)
        else $error("run did not stop at end marker");
    a_irq_step: assert property (
        s_step_done ##0 cur_cfg[ssq_pkg::CFG_IRQ] |=> irq_stat[$past(cur_seq)])
        else $error("step interrupt status not raised");
    a_step_order: assert property (
        s_step_done ##0 !run_end
        |=> state == ssq_pkg::ST_START && step_index == 3'($past(step_index) + 3'h1))
        else $error("steps not taken in ascending order");
    a_run_start: assert property (
        s_run_begin |=> state == ssq_pkg::ST_START && step_index == 3'h0 ##1 conv_start)
        else $error("triggered run did not begin at step zero");
    a_fill_cap: assert property (
        fill[0] <= ssq_pkg::CAP_SEQ0 && fill[1] <= ssq_pkg::CAP_SEQ12
        && fill[2] <= ssq_pkg::CAP_SEQ12 && fill[3] <= ssq_pkg::CAP_SEQ3)
        else $error("FIFO fill beyond sequence capacity");
    a_prio_win: assert property (
        s_run_begin ##0 pending[1:0] == 2'h3 && seq_prio[1:0] < seq_prio[3:2]
        |=> cur_seq != 2'h1)
        else $error("lower priority sequence won arbitration");
    a_disabled_quiet: assert property (
        (trig_evt & ~seq_en & ~pending) != 4'h0
        |=> (pending & $past(trig_evt & ~seq_en & ~pending)) == 4'h0)
        else $error("disabled sequence accepted a trigger");
    a_last_slot: assert property (
        s_step_done ##0 ({1'b0, step_index} == ssq_pkg::seq_cap(cur_seq) - 4'h1)
        |=> state == ssq_pkg::ST_IDLE)
        else $error("run passed the last step slot");
    a_bus_answer: assert property (
        (read || write) && waitrequest && !bus_phase && !$past(read || write)
        |-> ##2 !waitrequest)
        else $error("slave did not answer two cycles after request");

endmodule : ssq_sequencer

// ===== ssq_pkg.sv
// Shared constants for the sample sequencer: register map, step word layout,
// sequence capacities, interrupt bit groups and the sequencer state codes.
// Assumes a 32-bit Avalon-MM slave with byte addresses on an 8-bit address.
package ssq_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_SEQ = 4;
    localparam int MAX_STEPS = 8;
    localparam int DATA_W = 12;
    localparam int ADDR_W = 8;
    localparam int MEM_AW = 5;
    localparam int PRIO_W = 2;

    // ************************************************************
    // Step configuration word
    // ************************************************************
    localparam int CFG_W = 7;
    localparam int CFG_SEL_LO = 0;
    localparam int CFG_DIFF = 3;
    localparam int CFG_TEMP = 4;
    localparam int CFG_LAST = 5;
    localparam int CFG_IRQ = 6;

    // ************************************************************
    // Register map (byte offsets)
    // ************************************************************
    localparam logic [7:0] REG_ENABLE = 8'h00;
    localparam logic [7:0] REG_PRIO = 8'h04;
    localparam logic [7:0] REG_TRIGGER = 8'h08;
    localparam logic [7:0] REG_OVF = 8'h0c;
    localparam logic [7:0] REG_UNF = 8'h10;
    localparam logic [7:0] REG_IRQ_STAT = 8'h14;
    localparam logic [7:0] REG_IRQ_MASK = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [7:0] REG_FIFO_BASE = 8'h20;
    localparam logic [7:0] REG_FIFO_SPAN = 8'h10;
    localparam logic [7:0] REG_STEP_BASE = 8'h40;
    localparam logic [7:0] REG_STEP_SPAN = 8'h80;
    localparam int STEP_SEQ_LSB = 5;
    localparam int WORD_LSB = 2;

    // ************************************************************
    // Reset values and field positions
    // ************************************************************
    localparam logic [7:0] PRIO_RST = 8'he4;
    localparam int IRQ_W = 12;
    localparam int IRQ_DONE_LSB = 0;
    localparam int IRQ_OVF_LSB = 4;
    localparam int IRQ_UNF_LSB = 8;
    localparam int STAT_SEQ_LSB = 16;
    localparam int STAT_BUSY = 18;

    localparam logic [3:0] CAP_SEQ0 = 4'h8;
    localparam logic [3:0] CAP_SEQ12 = 4'h4;
    localparam logic [3:0] CAP_SEQ3 = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_START = 3'h2,
        ST_WAIT = 3'h4
    } ssq_state_e;

    function automatic logic [3:0] seq_cap(input logic [1:0] s);
        case (s)
            2'h0: return CAP_SEQ0;
            2'h3: return CAP_SEQ3;
            default: return CAP_SEQ12;
        endcase
    endfunction : seq_cap

endpackage : ssq_pkg

// ===== ssq_mem_if.sv
// Write and read port of the sample store between sequencer and memory.
// Assumes one clock; read data appear one edge after the read address.
`timescale 1ns/1ps
interface ssq_mem_if;
    logic wr_en;
    logic [ssq_pkg::MEM_AW-1:0] waddr;
    logic [ssq_pkg::DATA_W-1:0] wdata;
    logic [ssq_pkg::MEM_AW-1:0] raddr;
    logic [ssq_pkg::DATA_W-1:0] rdata;

    modport ctrl (output wr_en, output waddr, output wdata, output raddr, input rdata);
    modport mem (input wr_en, input waddr, input wdata, input raddr, output rdata);
endinterface : ssq_mem_if

// ===== ssq_sample_mem.sv
// Sample store holding the four output FIFOs, one slot group per sequence.
// Assumes the owner keeps its own pointers; read data are registered.
`timescale 1ns/1ps
module ssq_sample_mem (
    input wire logic clk,
    ssq_mem_if.mem port
);
    logic [ssq_pkg::DATA_W-1:0] store [2**ssq_pkg::MEM_AW];

    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            store[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge clk) begin
        port.rdata <= store[port.raddr];
    end
endmodule : ssq_sample_mem

// ===== ssq_conv_model.sv
// Converter stand-in: one done pulse per start, lag plus two cycles after it.
// Assumes start is one cycle wide and the selects hold until done.
`timescale 1ns/1ps
module ssq_conv_model (
    input wire logic clk,
    input wire logic conv_start,
    input wire logic [2:0] conv_input_p,
    input wire logic [2:0] conv_input_n,
    input wire logic conv_diff,
    input wire logic conv_temp,
    input wire logic [3:0] lag,
    output logic conv_done = 1'b0,
    output logic [11:0] conv_data = 12'h0
);
    logic [4:0] cnt = 5'h0;
    always_ff @(posedge clk) begin
        cnt <= conv_start ? {1'b0, lag} + 5'h1 : (cnt != 5'h0 ? cnt - 5'h1 : cnt);
        conv_done <= cnt == 5'h1;
        // Data flip outside the done cycle, so a capture one cycle late never matches
        conv_data <= cnt != 5'h1 ? ~conv_data : conv_temp ? 12'hb00 :
            {4'ha, 1'b0, conv_diff, conv_input_p, conv_input_n};
    end
endmodule : ssq_conv_model

// ===== ssq_sequencer_tb.sv
// Self-checking bench for the sample sequencer with a converter stand-in.
// Assumes the register map and bus timing of the sequencer package.
`timescale 1ns/1ps
module ssq_sequencer_tb;
    logic clk, rstn, read, write, waitrequest, conv_start, conv_diff, conv_temp, conv_done, irq;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rv;
    logic [3:0] trig_in, lag;
    logic [2:0] conv_input_p, conv_input_n;
    logic [11:0] conv_data;
    logic [18:0] rows [8];
    int n_errors, samples_checked;
    ssq_sequencer dut_u (.*);
    ssq_conv_model conv_u (.*);
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rv = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic chk(input logic [31:0] e);
        samples_checked++;
        if (rv !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, rv, e);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        bus(1'b0, a, 32'h0);
        rv = rv & m;
        chk(e);
    endtask : rc
    task automatic ck_irq(input logic e);
        #1 rv = {31'h0, irq};
        chk({31'h0, e});
    endtask : ck_irq
    task automatic settle();
        repeat (80) begin
            bus(1'b0, 8'h1c, 32'h0);
            if (rv[ssq_pkg::STAT_BUSY] === 1'b0) break;
        end
    endtask : settle
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #100000 n_errors++;
        wrap_up();
    end
    initial begin
        // Step word in [18:12], sample it should give in [11:0]
        rows = '{19'h07a3f, 19'h0aa65, 19'h10b00, 19'h40a00, 19'h0ba77, 19'h03a1b, 19'h08a41,
            19'h45a2d};
        {rstn, read, write, address, writedata, trig_in, lag} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rc(8'h04, 32'he4);
        for (int i = 0; i < 8; i++) bus(1'b1, 8'h40 + 8'(4 * i), {25'h0, rows[i][18:12]});
        bus(1'b1, 8'h18, 32'h1);
        bus(1'b1, 8'h00, 32'h3);
        lag <= 4'h9;
        bus(1'b1, 8'h08, 32'h1);
        settle();
        rc(8'h1c, 32'h8, 32'hffff);
        ck_irq(1'b1);
        for (int i = 0; i < 8; i++) rc(8'h20, {20'h0, rows[i][11:0]});
        rc(8'h14, 32'h1);
        rc(8'h20, 32'h0);
        rc(8'h10, 32'h1);
        bus(1'b1, 8'h10, 32'h1);
        rc(8'h10, 32'h0);
        $display("test 1 done");
        bus(1'b1, 8'h60, 32'h01);
        bus(1'b1, 8'h64, 32'h22);
        lag <= 4'h0;
        trig_in <= 4'h6;
        @(posedge clk);
        trig_in <= 4'h0;
        settle();
        rc(8'h1c, 32'h20, 32'hffff);
        trig_in <= 4'h2;
        @(posedge clk);
        trig_in <= 4'h0;
        settle();
        rc(8'h0c, 32'h2);
        rc(8'h1c, 32'h40, 32'hffff);
        bus(1'b1, 8'h0c, 32'h2);
        rc(8'h0c, 32'h0);
        for (int i = 0; i < 4; i++) rc(8'h24, i[0] ? 32'ha12 : 32'ha09);
        $display("test 2 done");
        ck_irq(1'b0);
        bus(1'b1, 8'h18, 32'h20);
        ck_irq(1'b1);
        rc(8'h14, 32'h120);
        ck_irq(1'b0);
        $display("test 3 done");
        // Both FIFOs are empty; sequence zero must win and sequence one runs last
        trig_in <= 4'h3;
        @(posedge clk);
        trig_in <= 4'h0;
        // Busy drops for one idle cycle between the two runs, so settle twice
        settle();
        settle();
        rc(8'h1c, 32'h10028, 32'h7ffff);
        $display("test 4 done");
        wrap_up();
    end
endmodule : ssq_sequencer_tb
